// >>> hdl/ioc_compare_and_config.sv
// Interrupt-on-change compare logic and expander configuration register
`timescale 1ns/1ps

module ioc_compare_and_config
	import ioc_config_pkg::*;
#(
	parameter bit SPI_VARIANT = 1'b1
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  clockEnable,
	// Byte interface from the serial protocol engine
	input  wire logic                  addressLoad,
	input  wire logic [ADDR_WIDTH-1:0] addressIn,
	input  wire logic                  byteWrite,
	input  wire logic [7:0]            writeData,
	input  wire logic                  byteRead,
	output logic      [7:0]            readData,
	output logic                       readHit,
	output logic      [ADDR_WIDTH-1:0] pointer,
	// Per-port state from the surrounding port logic (same clock)
	input  wire logic [7:0]            portAValue,
	input  wire logic [7:0]            portBValue,
	input  wire logic [7:0]            directionPortA,
	input  wire logic [7:0]            directionPortB,
	input  wire logic [7:0]            pinChangeIrqEnableA,
	input  wire logic [7:0]            pinChangeIrqEnableB,
	input  wire logic                  irqClearA,
	input  wire logic                  irqClearB,
	output logic      [7:0]            changeFlagsA,
	output logic      [7:0]            changeFlagsB,
	// External pins
	input  wire logic                  addrPin2,
	input  wire logic                  addrPin1,
	input  wire logic                  addrPin0,
	output logic      [2:0]            deviceAddress,
	output logic                       sdaSlewDisable,
	output logic                       irqPinAOut,
	output logic                       irqPinAOe,
	output logic                       irqPinBOut,
	output logic                       irqPinBOe
);

	// ==========================================================
	// Register storage
	logic [7:0] defaultCompare [2];
	logic [7:0] compareSelect  [2];
	logic [7:0] expanderConfig;
	logic [7:0] next_defaultCompare [2];
	logic [7:0] next_compareSelect  [2];
	logic [7:0] next_expanderConfig;
	logic [ADDR_WIDTH-1:0] next_pointer;
	logic [7:0] next_readData;
	logic       next_readHit;

	reg_kind_type decodeKind;
	logic         decodePort;
	logic         decodeValid;

	// ==========================================================
	// Address decode
	// Decode reads the live bank bit, so a change applies from the next byte on.
	always_comb begin
		decodeKind  = REG_NONE;
		decodePort  = 1'b0;
		decodeValid = 1'b0;
		if (expanderConfig[CFG_BANK_BIT]) begin
			if (pointer <= BANK_A_LAST) begin
				decodeValid = 1'b1;
				decodePort  = 1'b0;
			end else if (pointer >= BANK_B_BASE && pointer <= BANK_B_LAST) begin
				decodeValid = 1'b1;
				decodePort  = 1'b1;
			end
			case (pointer[3:0])
				IDX_DEFAULT_COMPARE: decodeKind = REG_DEFAULT_COMPARE;
				IDX_COMPARE_SELECT:  decodeKind = REG_COMPARE_SELECT;
				IDX_CONFIG:          decodeKind = REG_CONFIG;
				default:             decodeKind = REG_NONE;
			endcase
		end else begin
			if (pointer <= PAIRED_LAST) begin
				decodeValid = 1'b1;
				decodePort  = pointer[0];
			end
			case (pointer[4:1])
				IDX_DEFAULT_COMPARE: decodeKind = REG_DEFAULT_COMPARE;
				IDX_COMPARE_SELECT:  decodeKind = REG_COMPARE_SELECT;
				IDX_CONFIG:          decodeKind = REG_CONFIG;
				default:             decodeKind = REG_NONE;
			endcase
		end
		if (!decodeValid) begin
			decodeKind = REG_NONE;
		end
	end

	// ==========================================================
	// Register write, read and pointer
	always_comb begin
		next_defaultCompare = defaultCompare;
		next_compareSelect  = compareSelect;
		next_expanderConfig = expanderConfig;
		next_pointer        = pointer;
		next_readData       = readData;
		next_readHit        = 1'b0;
		if (addressLoad) begin
			// pointer loaded as given, never remapped
			next_pointer = addressIn;
		end else if (byteWrite || byteRead) begin
			if (byteWrite) begin
				case (decodeKind)
					REG_DEFAULT_COMPARE: next_defaultCompare[decodePort] = writeData;
					REG_COMPARE_SELECT:  next_compareSelect[decodePort]  = writeData;
					REG_CONFIG:          next_expanderConfig = writeData & CFG_IMPL_MASK;
					default:             next_expanderConfig = expanderConfig;
				endcase
			end else begin
				next_readHit = (decodeKind != REG_NONE);
				case (decodeKind)
					REG_DEFAULT_COMPARE: next_readData = defaultCompare[decodePort];
					REG_COMPARE_SELECT:  next_readData = compareSelect[decodePort];
					REG_CONFIG:          next_readData = expanderConfig & CFG_IMPL_MASK;
					default:             next_readData = 8'h00;
				endcase
			end
			// pointer advance unless sequential operation is off
			// no wrap fix-up; a banked pointer at 0Bh just decodes to nothing
			if (!expanderConfig[CFG_SEQ_BIT]) begin
				next_pointer = ADDR_WIDTH'(pointer + 1'b1);
			end
		end
	end

	// Single configuration register shared by both port addresses
	always_ff @(posedge clock) begin
		if (rst) begin
			defaultCompare[0] <= DEFAULT_COMPARE_RESET;
			defaultCompare[1] <= DEFAULT_COMPARE_RESET;
			compareSelect[0]  <= COMPARE_SELECT_RESET;
			compareSelect[1]  <= COMPARE_SELECT_RESET;
			expanderConfig    <= CONFIG_RESET;
			pointer           <= POINTER_RESET;
			readData          <= 8'h00;
			readHit           <= 1'b0;
		end else if (clockEnable) begin
			defaultCompare <= next_defaultCompare;
			compareSelect  <= next_compareSelect;
			expanderConfig <= next_expanderConfig;
			pointer        <= next_pointer;
			readData       <= next_readData;
			readHit        <= next_readHit;
		end
	end

	// ==========================================================
	// Interrupt-on-change compare, one generate per pin
	logic [7:0] pinValue       [2];
	logic [7:0] pinInput       [2];
	logic [7:0] pinEnable      [2];
	logic [7:0] previousValue  [2];
	logic [7:0] flags          [2];
	logic [7:0] next_flags     [2];
	logic [7:0] mismatch       [2];
	logic       portClear      [2];

	assign pinValue[0]  = portAValue;
	assign pinValue[1]  = portBValue;
	assign pinInput[0]  = directionPortA;
	assign pinInput[1]  = directionPortB;
	assign pinEnable[0] = pinChangeIrqEnableA;
	assign pinEnable[1] = pinChangeIrqEnableB;
	assign portClear[0] = irqClearA;
	assign portClear[1] = irqClearB;

	genvar p, b;
	generate
		for (p = 0; p < 2; p++) begin : gen_port
			for (b = 0; b < PORT_WIDTH; b++) begin : gen_pin
				logic reference;
				// mode bit picks default or previous value
				assign reference = compareSelect[p][b] ? defaultCompare[p][b] : previousValue[p][b];
				// opposite level flags; enable gate; inputs only
				assign mismatch[p][b] = pinEnable[p][b] & pinInput[p][b] & (pinValue[p][b] != reference);
			end
			// A new mismatch wins over a clear in the same cycle
			assign next_flags[p] = (portClear[p] ? 8'h00 : flags[p]) | mismatch[p];
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst) begin
			flags[0]         <= 8'h00;
			flags[1]         <= 8'h00;
			previousValue[0] <= 8'h00;
			previousValue[1] <= 8'h00;
		end else if (clockEnable) begin
			flags            <= next_flags;
			previousValue    <= pinValue;
		end
	end

	assign changeFlagsA = flags[0];
	assign changeFlagsB = flags[1];

	// ==========================================================
	// Interrupt pin drive and configuration outputs
	logic portIrqA;
	logic portIrqB;
	logic activeA;
	logic activeB;

	assign portIrqA = |flags[0];
	assign portIrqB = |flags[1];

	always_comb begin
		if (expanderConfig[CFG_MIRROR_BIT]) begin
			activeA = portIrqA | portIrqB;
			activeB = portIrqA | portIrqB;
		end else begin
			activeA = portIrqA;
			activeB = portIrqB;
		end
		// open drain pulls low only when active
		if (expanderConfig[CFG_DRAIN_BIT]) begin
			irqPinAOut = 1'b0;
			irqPinBOut = 1'b0;
			irqPinAOe  = activeA;
			irqPinBOe  = activeB;
		end else begin
			// polarity sets the driven active level
			irqPinAOut = expanderConfig[CFG_POL_BIT] ? activeA : ~activeA;
			irqPinBOut = expanderConfig[CFG_POL_BIT] ? activeB : ~activeB;
			irqPinAOe  = 1'b1;
			irqPinBOe  = 1'b1;
		end
	end

	// Address pins are static straps, still synchronised since they come from outside
	logic [2:0] addrSync1;
	logic [2:0] addrSync2;
	always_ff @(posedge clock) begin
		if (rst) begin
			addrSync1 <= 3'h0;
			addrSync2 <= 3'h0;
		end else if (clockEnable) begin
			addrSync1 <= {addrPin2, addrPin1, addrPin0};
			addrSync2 <= addrSync1;
		end
	end

	// address pins, or zero on the SPI variant while the address-enable bit is clear
	assign deviceAddress  = (!SPI_VARIANT || expanderConfig[CFG_ADDR_EN_BIT]) ? addrSync2 : 3'h0;
	// slew disable straight from the configuration
	assign sdaSlewDisable = expanderConfig[CFG_SLEW_BIT];

endmodule

// >>> hdl/ioc_config_pkg.sv
// Constants shared by the interrupt-on-change compare and configuration block
package ioc_config_pkg;

	// ==========================================================
	// Register layout
	localparam int ADDR_WIDTH    = 5;
	localparam int PORT_WIDTH    = 8;
	localparam int REG_COUNT     = 11;
	// Register index within one port bank
	localparam logic [3:0] IDX_DEFAULT_COMPARE = 4'h3;
	localparam logic [3:0] IDX_COMPARE_SELECT  = 4'h4;
	localparam logic [3:0] IDX_CONFIG          = 4'h5;
	// Banked map: port B bank base
	localparam logic [4:0] BANK_B_BASE   = 5'h10;
	localparam logic [4:0] BANK_A_LAST   = 5'h0A;
	localparam logic [4:0] BANK_B_LAST   = 5'h1A;
	localparam logic [4:0] PAIRED_LAST   = 5'h15;

	// ==========================================================
	// Configuration bit positions
	localparam int CFG_BANK_BIT     = 7;
	localparam int CFG_MIRROR_BIT   = 6;
	localparam int CFG_SEQ_BIT      = 5;
	localparam int CFG_SLEW_BIT     = 4;
	localparam int CFG_ADDR_EN_BIT  = 3;
	localparam int CFG_DRAIN_BIT    = 2;
	localparam int CFG_POL_BIT      = 1;
	localparam logic [7:0] CFG_IMPL_MASK = 8'hFE;

	// ==========================================================
	// Reset values
	localparam logic [7:0] DEFAULT_COMPARE_RESET = 8'h00;
	localparam logic [7:0] COMPARE_SELECT_RESET  = 8'h00;
	localparam logic [7:0] CONFIG_RESET          = 8'h00;
	localparam logic [4:0] POINTER_RESET         = 5'h00;

	typedef enum logic [1:0] {
		REG_NONE,
		REG_DEFAULT_COMPARE,
		REG_COMPARE_SELECT,
		REG_CONFIG
	} reg_kind_type;

endpackage

// >>> testbench/ioc_compare_and_config_properties.sv
// Port-level checks for the compare and configuration block
`timescale 1ns/1ps

module ioc_compare_checker
	import ioc_config_pkg::*;
(
	input wire logic                  clock,
	input wire logic                  rst,
	input wire logic                  clockEnable,
	input wire logic                  addressLoad,
	input wire logic [ADDR_WIDTH-1:0] addressIn,
	input wire logic                  byteWrite,
	input wire logic                  byteRead,
	input wire logic [7:0]            readData,
	input wire logic                  readHit,
	input wire logic [ADDR_WIDTH-1:0] pointer,
	input wire logic [7:0]            directionPortA,
	input wire logic [7:0]            pinChangeIrqEnableA,
	input wire logic                  irqClearA,
	input wire logic [7:0]            changeFlagsA,
	input wire logic [7:0]            changeFlagsB,
	input wire logic                  irqPinAOut,
	input wire logic                  irqPinAOe,
	input wire logic                  irqPinBOut,
	input wire logic                  irqPinBOe
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	chk_flag_cause: assert property (
		((changeFlagsA & ~$past(changeFlagsA)) & ~$past(pinChangeIrqEnableA & directionPortA)) == 8'h00)
		else $error("flag set on a disabled or output pin");
	chk_flag_sticky: assert property (
		!$past(rst) && (($past(changeFlagsA) & ~changeFlagsA) != 8'h00) |-> $past(irqClearA))
		else $error("flag dropped without a clear");
	chk_pins_paired: assert property (
		((changeFlagsA != 8'h00) == (changeFlagsB != 8'h00)) |-> {irqPinAOut, irqPinAOe} == {irqPinBOut, irqPinBOe})
		else $error("interrupt pins differ with equal port state");
	chk_released_low: assert property (
		(!irqPinAOe -> !irqPinAOut) && (!irqPinBOe -> !irqPinBOut))
		else $error("undriven interrupt pin shows high");
	chk_active_drives: assert property (
		(changeFlagsA != 8'h00) |-> irqPinAOe)
		else $error("active interrupt pin not driven");
	chk_hit_cause: assert property (
		readHit |-> $past(byteRead && clockEnable && !addressLoad && !byteWrite))
		else $error("read hit without a read");
	chk_miss_zero: assert property (
		!$past(rst) && $past(byteRead && clockEnable && !addressLoad && !byteWrite) && !readHit
		|-> readData == 8'h00) else $error("unmapped read not zero");
	chk_pointer_load: assert property (
		addressLoad && clockEnable |=> pointer == $past(addressIn))
		else $error("pointer not loaded");
	chk_pointer_step: assert property (
		(byteWrite || byteRead) && !addressLoad && clockEnable |=> 5'(pointer - $past(pointer)) <= 5'h01)
		else $error("pointer moved by more than one");

	chk_freeze_hold: assert property (
		!clockEnable |=> $stable(pointer) && $stable(changeFlagsA) && $stable(readData))
		else $error("state moved while clock enable low");

	cover property (readHit);
	cover property (!clockEnable && (changeFlagsB != 8'h00));
	cover property (changeFlagsA != 8'h00);
	cover property (!irqPinAOe);
endmodule

bind ioc_compare_and_config ioc_compare_checker chk (.*);

// >>> testbench/serial_host_model.sv
// Byte-level model of the serial host feeding the block
`timescale 1ns/1ps

module serial_host_model
	import ioc_config_pkg::*;
(
	input wire logic                   clock,
	output logic                       addressLoad,
	output logic      [ADDR_WIDTH-1:0] addressIn,
	output logic                       byteWrite,
	output logic      [7:0]            writeData,
	output logic                       byteRead
);
	initial begin
		{addressLoad, byteWrite, byteRead} = 3'b000;
		addressIn = 5'h00;
		writeData = 8'h00;
	end

	// ==========================================================
	// One strobe per cycle, set at the falling edge
	// bank bit is changed only by single-byte writes from the bench
	task automatic op(input logic l, w, r, input logic [7:0] d);
		@(negedge clock);
		addressLoad = l;
		byteWrite = w;
		byteRead = r;
		// Idle data lines toggle so a stale value is never read as valid
		addressIn = l ? d[4:0] : ~addressIn;
		writeData = w ? d : ~writeData;
	endtask
endmodule

// >>> testbench/tb_ioc_compare_and_config.sv
// Self-checking bench for the compare and configuration block
`timescale 1ns/1ps

module tb_ioc_compare_and_config
	import ioc_config_pkg::*;
;
	logic       clock, rst, clockEnable, addressLoad, byteWrite, byteRead, readHit;
	logic [4:0] addressIn, pointer;
	logic [7:0] writeData, readData, portAValue, portBValue, directionPortA, directionPortB;
	logic [7:0] pinChangeIrqEnableA, pinChangeIrqEnableB, changeFlagsA, changeFlagsB;
	logic       irqClearA, irqClearB, addrPin2, addrPin1, addrPin0, sdaSlewDisable;
	logic       irqPinAOut, irqPinAOe, irqPinBOut, irqPinBOe;
	logic [2:0] deviceAddress;
	int         n_errors = 0;
	int         n_tests = 0;

	ioc_compare_and_config dut (.*);
	serial_host_model host (.*);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ==========================================================
	// Helpers
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		host.op(1'b1, 1'b0, 1'b0, a);
		host.op(1'b0, 1'b1, 1'b0, d);
		host.op(1'b0, 1'b0, 1'b0, 8'h00);
	endtask
	task automatic rd(input logic [7:0] a, e, input logic h);
		host.op(1'b1, 1'b0, 1'b0, a);
		host.op(1'b0, 1'b0, 1'b1, 8'h00);
		host.op(1'b0, 1'b0, 1'b0, 8'h00);
		chk("readData", e, readData);
		chk("readHit", {7'h00, h}, {7'h00, readHit});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic clr();
		irqClearA = 1'b1;
		tick(1);
		irqClearA = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		report_and_stop();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{rst, clockEnable, irqClearA, irqClearB} = 4'b1100;
		{addrPin2, addrPin1, addrPin0} = 3'b101;
		{portAValue, portBValue, directionPortA, directionPortB} = 32'h0000_FF00;
		{pinChangeIrqEnableA, pinChangeIrqEnableB} = 16'h0000;
		tick(12);
		rst = 1'b0;
		rd(8'h06, 8'h00, 1'b1);
		rd(8'h08, 8'h00, 1'b1);
		rd(8'h0A, 8'h00, 1'b1);
		rd(8'h00, 8'h00, 1'b0);
		wr(8'h06, 8'hA5);
		rd(8'h06, 8'hA5, 1'b1);
		wr(8'h08, 8'h3C);
		rd(8'h08, 8'h3C, 1'b1);
		wr(8'h0A, 8'h5F);
		rd(8'h0B, 8'h5E, 1'b1);
		chk("slew", 8'h01, {7'h00, sdaSlewDisable});
		chk("devAddr", 8'h05, {5'h00, deviceAddress});
		chk("irqA", 8'h00, {6'h00, irqPinAOe, irqPinAOut});
		host.op(1'b1, 1'b0, 1'b0, 8'h06);
		host.op(1'b0, 1'b1, 1'b0, 8'h11);
		host.op(1'b0, 1'b1, 1'b0, 8'h22);
		host.op(1'b0, 1'b0, 1'b0, 8'h00);
		chk("pointer", 8'h08, {3'h0, pointer});
		rd(8'h07, 8'h22, 1'b1);
		wr(8'h0A, 8'h7F);
		host.op(1'b1, 1'b0, 1'b0, 8'h06);
		host.op(1'b0, 1'b1, 1'b0, 8'h33);
		host.op(1'b0, 1'b1, 1'b0, 8'h44);
		host.op(1'b0, 1'b0, 1'b0, 8'h00);
		chk("pointer", 8'h06, {3'h0, pointer});
		rd(8'h06, 8'h44, 1'b1);
		wr(8'h0A, 8'h02);
		chk("devAddr", 8'h00, {5'h00, deviceAddress});
		chk("irqA", 8'h02, {6'h00, irqPinAOe, irqPinAOut});
		wr(8'h06, 8'h00);
		wr(8'h08, 8'h01);
		// Bit 1 input but disabled, bit 2 enabled but an output
		pinChangeIrqEnableA = 8'h05;
		directionPortA = 8'hFB;
		portAValue = 8'h07;
		tick(2);
		chk("flagsA", 8'h01, changeFlagsA);
		chk("irqA", 8'h03, {6'h00, irqPinAOe, irqPinAOut});
		chk("irqB", 8'h02, {6'h00, irqPinBOe, irqPinBOut});
		wr(8'h0A, 8'h42);
		chk("irqB", 8'h03, {6'h00, irqPinBOe, irqPinBOut});
		wr(8'h08, 8'h00);
		wr(8'h0A, 8'h00);
		chk("irqA", 8'h02, {6'h00, irqPinAOe, irqPinAOut});
		clr();
		tick(2);
		chk("flagsA", 8'h00, changeFlagsA);
		chk("irqA", 8'h03, {6'h00, irqPinAOe, irqPinAOut});
		portAValue = 8'h00;
		tick(2);
		chk("flagsA", 8'h01, changeFlagsA);
		clr();
		wr(8'h0A, 8'h80);
		chk("pointer", 8'h0B, {3'h0, pointer});
		host.op(1'b0, 1'b0, 1'b1, 8'h00);
		host.op(1'b0, 1'b0, 1'b0, 8'h00);
		chk("readHit", 8'h00, {7'h00, readHit});
		rd(8'h05, 8'h80, 1'b1);
		rd(8'h15, 8'h80, 1'b1);
		rd(8'h13, 8'h22, 1'b1);
		rd(8'h0A, 8'h00, 1'b0);
		// Port B source, mirror and open drain in the banked map
		wr(8'h13, 8'hFF);
		wr(8'h14, 8'h80);
		directionPortB = 8'h80;
		pinChangeIrqEnableB = 8'h80;
		tick(2);
		chk("flagsB", 8'h80, changeFlagsB);
		chk("irqA", 8'h03, {6'h00, irqPinAOe, irqPinAOut});
		chk("irqB", 8'h02, {6'h00, irqPinBOe, irqPinBOut});
		wr(8'h15, 8'hC4);
		chk("irqA", 8'h02, {6'h00, irqPinAOe, irqPinAOut});
		chk("irqB", 8'h02, {6'h00, irqPinBOe, irqPinBOut});
		// Clear while the mismatch persists: the set wins
		irqClearB = 1'b1;
		tick(1);
		irqClearB = 1'b0;
		chk("flagsB", 8'h80, changeFlagsB);
		portBValue = 8'h80;
		tick(1);
		irqClearB = 1'b1;
		tick(1);
		irqClearB = 1'b0;
		chk("flagsB", 8'h00, changeFlagsB);
		chk("irqA", 8'h00, {6'h00, irqPinAOe, irqPinAOut});
		// Frozen clock enable: no write, no pointer step, no flag
		clockEnable = 1'b0;
		wr(8'h15, 8'h00);
		portBValue = 8'h00;
		tick(2);
		chk("flagsB", 8'h00, changeFlagsB);
		clockEnable = 1'b1;
		chk("pointer", 8'h16, {3'h0, pointer});
		tick(1);
		chk("flagsB", 8'h80, changeFlagsB);
		rd(8'h15, 8'hC4, 1'b1);
		tick(3);
		chk("readData", 8'hC4, readData);
		// Mid-run reset returns every register to zero
		rst = 1'b1;
		tick(1);
		rst = 1'b0;
		chk("flagsB", 8'h00, changeFlagsB);
		chk("irqA", 8'h03, {6'h00, irqPinAOe, irqPinAOut});
		rd(8'h0A, 8'h00, 1'b1);
		rd(8'h07, 8'h00, 1'b1);
		rd(8'h09, 8'h00, 1'b1);
		report_and_stop();
	end
endmodule
